// [hdl/crf_freq_measure.sv]
// Capacitance/resistance-to-frequency measurement block with APB registers.
// Assumes an APB master on clk and an RC oscillator signal on rcOscIn.
// Overview of operation
// (R01) Two independent 16-bit count-up counters, A and B, measure the frequency.
// (R02) Counter A counts system clock, or system clock divided by four.
// (R03) Counter B counts edges of the external RC oscillator.
// (R04) Overflow-select bit picks counter A or B overflow as the end.
// (R05) Selected overflow sets the done flag and requests the interrupt.
// (R06) Selected overflow clears the run bit and stops both counters together.
// (R07) Setting the run bit starts both counters until the selected overflow.
// (R08) Low-byte write only fills the shared buffer; counters stay unchanged.
// (R09) High-byte write loads high byte plus buffered low byte at once.
// (R10) High-byte read copies the counter's low byte into the buffer.
// (R11) Low-byte read returns the buffer; software reads high byte first.
// (R12) While running, counter byte reads and writes have no effect.
// (R13) Two select registers route one of nine channels to the oscillator.
// (R14) Pull-low register grounds inactive channels, one bit per channel pair.
// (R15) Select bits of channels used as plain I/O do nothing, read zero.
// (R16) Software clears pull-low bits of channels used as plain I/O.
// (R17) Software keeps pull-low register bits seven to five at zero.
// (R18) Overflow is a running counter wrapping to zero; idle counters hold.
//
// Chosen here: the address map and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "crf_params.svh"
module crf_freq_measure
  import crf_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rcOscIn,
  input wire logic [7:0] ioModeLow,
  input wire logic ioModeHigh,
  output crf_switch_t switchCtrl,
  output logic irq
);
  crf_state_t state_q, state_d;
  logic refSel_q, refSel_d;
  logic ovfSel_q, ovfSel_d;
  logic [7:0] lowBuf_q, lowBuf_d;
  logic [7:0] chanLow_q, chanLow_d;
  logic chanHigh_q, chanHigh_d;
  logic [7:0] pull_q, pull_d;
  logic flag_q, flag_d;
  logic irqEn_q, irqEn_d;
  logic [1:0] pre_q, pre_d;
  logic [31:0] prdata_q, prdata_d;
  logic pslverr_q, pslverr_d;
  crf_switch_t switch_q, switch_d;
  logic oscPrev_q;
  logic oscSync;
  logic setup, access, wr, rd, running;
  logic tickA, tickB, ldA, ldB, wrapA, wrapB, selOvf;
  logic [15:0] cntA, cntB;
  logic [31:0] readValue;

  // Address match helper
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    return a == ofs;
  endfunction

  function automatic logic isMapped(input logic [7:0] a);
    return a[1:0] == 2'b00 && a <= `CRF_OFS_ENABLE;
  endfunction

  assign setup = psel && !penable;
  assign access = psel && penable;
  assign wr = access && pwrite;
  assign rd = access && !pwrite;
  assign running = state_q == CRF_RUN;

  crf_sync uOscSync (
    .clk(clk),
    .reset_n(reset_n),
    .asyncIn(rcOscIn),
    .syncOut(oscSync)
  );

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      oscPrev_q <= 1'b0;
    end else begin
      oscPrev_q <= oscSync;
    end
  end

  assign tickA = running && (!refSel_q || pre_q == `CRF_PRE_LAST); // see (R02)
  assign tickB = running && oscSync && !oscPrev_q; // see (R03)
  assign ldA = wr && !running && hit(paddr, `CRF_OFS_A_HIGH); // see (R09)
  assign ldB = wr && !running && hit(paddr, `CRF_OFS_B_HIGH); // see (R09)
  assign selOvf = running && (ovfSel_q ? wrapA : wrapB); // see (R04)

  crf_counter #(.WIDTH(16)) uCntA (
    .clk(clk),
    .reset_n(reset_n),
    .tick(tickA),
    .load(ldA),
    .loadValue({pwdata[7:0], lowBuf_q}),
    .count(cntA),
    .wrap(wrapA)
  );

  crf_counter #(.WIDTH(16)) uCntB (
    .clk(clk),
    .reset_n(reset_n),
    .tick(tickB),
    .load(ldB),
    .loadValue({pwdata[7:0], lowBuf_q}),
    .count(cntB),
    .wrap(wrapB)
  );

  // Read data, sampled in the setup phase
  always_comb begin
    readValue = `CRF_WORD_RST;
    case (paddr)
      `CRF_OFS_CTRL: begin
        readValue[`CRF_CTRL_RUN_BIT] = running;
        readValue[`CRF_CTRL_REFSEL_BIT] = refSel_q;
      end
      `CRF_OFS_MODE: readValue[`CRF_MODE_OVFSEL_BIT] = ovfSel_q;
      `CRF_OFS_A_LOW, `CRF_OFS_B_LOW: begin
        if (!running) readValue[7:0] = lowBuf_q; // see (R11), (R12)
      end
      `CRF_OFS_A_HIGH: if (!running) readValue[7:0] = cntA[15:8];
      `CRF_OFS_B_HIGH: if (!running) readValue[7:0] = cntB[15:8];
      `CRF_OFS_SEL_LOW: readValue[7:0] = chanLow_q & ~ioModeLow; // see (R15)
      `CRF_OFS_SEL_HIGH: readValue[0] = chanHigh_q && !ioModeHigh; // see (R15)
      `CRF_OFS_PULL: readValue[7:0] = pull_q;
      `CRF_OFS_STATUS: readValue[`CRF_FLAG_BIT] = flag_q;
      `CRF_OFS_ENABLE: readValue[`CRF_FLAG_BIT] = irqEn_q;
      default: readValue = `CRF_WORD_RST;
    endcase
  end

  always_comb begin
    state_d = state_q;
    refSel_d = refSel_q;
    ovfSel_d = ovfSel_q;
    lowBuf_d = lowBuf_q;
    chanLow_d = chanLow_q;
    chanHigh_d = chanHigh_q;
    pull_d = pull_q;
    flag_d = flag_q;
    irqEn_d = irqEn_q;
    pre_d = running ? pre_q + 2'h1 : `CRF_PRE_RST;
    prdata_d = (setup && !pwrite) ? readValue : prdata_q;
    pslverr_d = setup ? !isMapped(paddr) : pslverr_q;
    case (state_q)
      CRF_IDLE: begin
        if (wr && hit(paddr, `CRF_OFS_CTRL) && pwdata[`CRF_CTRL_RUN_BIT]) begin
          state_d = CRF_RUN; // see (R07)
        end
      end
      CRF_RUN: begin
        if (selOvf) begin
          state_d = CRF_IDLE; // see (R06)
        end else if (wr && hit(paddr, `CRF_OFS_CTRL)) begin
          if (!pwdata[`CRF_CTRL_RUN_BIT]) state_d = CRF_IDLE;
        end
      end
      default: state_d = CRF_IDLE;
    endcase
    if (wr) begin
      if (hit(paddr, `CRF_OFS_CTRL)) refSel_d = pwdata[`CRF_CTRL_REFSEL_BIT];
      if (hit(paddr, `CRF_OFS_MODE)) ovfSel_d = pwdata[`CRF_MODE_OVFSEL_BIT];
      if (hit(paddr, `CRF_OFS_SEL_LOW)) chanLow_d = pwdata[7:0];
      if (hit(paddr, `CRF_OFS_SEL_HIGH)) chanHigh_d = pwdata[0];
      // Upper bits are stored but drive nothing
      if (hit(paddr, `CRF_OFS_PULL)) pull_d = pwdata[7:0]; // see (R17)
      if (hit(paddr, `CRF_OFS_ENABLE)) irqEn_d = pwdata[`CRF_FLAG_BIT];
      if (hit(paddr, `CRF_OFS_CLEAR) && pwdata[`CRF_FLAG_BIT]) begin
        flag_d = 1'b0;
      end
    end
    if (!running) begin
      if (wr && (hit(paddr, `CRF_OFS_A_LOW) || hit(paddr, `CRF_OFS_B_LOW))) begin
        lowBuf_d = pwdata[7:0]; // see (R08)
      end
      if (rd && hit(paddr, `CRF_OFS_A_HIGH)) lowBuf_d = cntA[7:0]; // see (R10)
      if (rd && hit(paddr, `CRF_OFS_B_HIGH)) lowBuf_d = cntB[7:0]; // see (R10)
    end
    // A set in the clearing cycle wins
    if (selOvf) flag_d = 1'b1; // see (R05)
  end

  // Switch outputs: selected channel and pull-low of the inactive ones
  always_comb begin
    switch_d.select = {chanHigh_q && !ioModeHigh,
                       chanLow_q & ~ioModeLow}; // see (R13), (R15)
    for (int i = 0; i < 8; i++) begin
      switch_d.pullLow[i] = pull_q[i/2] && !switch_d.select[i]; // see (R14)
    end
    switch_d.pullLow[8] = pull_q[`CRF_PAIR_CH8_BIT] && !switch_d.select[8];
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= CRF_IDLE;
      refSel_q <= `CRF_BIT_RST;
      ovfSel_q <= `CRF_BIT_RST;
      lowBuf_q <= `CRF_BYTE_RST;
      chanLow_q <= `CRF_BYTE_RST;
      chanHigh_q <= `CRF_BIT_RST;
      pull_q <= `CRF_BYTE_RST;
      flag_q <= `CRF_BIT_RST;
      irqEn_q <= `CRF_BIT_RST;
      pre_q <= `CRF_PRE_RST;
      prdata_q <= `CRF_WORD_RST;
      pslverr_q <= `CRF_BIT_RST;
      switch_q <= '0;
    end else begin
      state_q <= state_d;
      refSel_q <= refSel_d;
      ovfSel_q <= ovfSel_d;
      lowBuf_q <= lowBuf_d;
      chanLow_q <= chanLow_d;
      chanHigh_q <= chanHigh_d;
      pull_q <= pull_d;
      flag_q <= flag_d;
      irqEn_q <= irqEn_d;
      pre_q <= pre_d;
      prdata_q <= prdata_d;
      pslverr_q <= pslverr_d;
      switch_q <= switch_d;
    end
  end

  assign prdata = prdata_q;
  assign pready = 1'b1;
  assign pslverr = pslverr_q;
  assign switchCtrl = switch_q;
  assign irq = flag_q && irqEn_q; // see (R05)

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  a_ovf_sets_flag: assert property (selOvf |=> flag_q) // see (R05)
    else $error("done flag not set by overflow");
  // The selected counter takes its wrapping tick, then both hold from the next edge on
  a_ovf_stops_run: assert property (selOvf |=> !running
    ##1 ($stable(cntA) && $stable(cntB))) // see (R06)
    else $error("counters kept running after overflow");
  a_ovf_source: assert property (running && wrapB && !ovfSel_q |-> selOvf)
    // see (R04)
    else $error("counter B overflow ignored");
  a_low_write_buf: assert property (wr && !running && hit(paddr,
    `CRF_OFS_A_LOW) |=> lowBuf_q == $past(pwdata[7:0]) && $stable(cntA))
    // see (R08)
    else $error("low byte write misbehaved");
  a_high_write_load: assert property (ldA |=>
    cntA == {$past(pwdata[7:0]), $past(lowBuf_q)}) // see (R09)
    else $error("high byte write did not load counter A");
  a_high_read_latch: assert property (rd && !running && hit(paddr,
    `CRF_OFS_B_HIGH) |=> lowBuf_q == $past(cntB[7:0])) // see (R10)
    else $error("high byte read did not latch low byte");
  a_low_read_buf: assert property (setup && !pwrite && !running
    && hit(paddr, `CRF_OFS_A_LOW) |=> prdata == {24'h0, $past(lowBuf_q)})
    // see (R11)
    else $error("low byte read not from buffer");
  a_run_locks_bytes: assert property (running && access && hit(paddr,
    `CRF_OFS_A_LOW) |=> $stable(lowBuf_q)) // see (R12)
    else $error("counter byte access while running");
  a_div4_rate: assert property (running && refSel_q && tickA |=>
    !tickA [*3]) // see (R02)
    else $error("divided clock ticks too often");
  a_io_reads_zero: assert property (setup && !pwrite && hit(paddr,
    `CRF_OFS_SEL_LOW) |=> (prdata[7:0] & $past(ioModeLow)) == 8'h00)
    // see (R15)
    else $error("plain I/O select bit read nonzero");
  a_idle_holds: assert property (!running && !ldA |=> $stable(cntA))
    // see (R18)
    else $error("idle counter changed");

  a_run_starts: assert property (wr && !running && hit(paddr, `CRF_OFS_CTRL)
    && pwdata[`CRF_CTRL_RUN_BIT] |=> running) // see (R07)
    else $error("run bit did not start the counters");

  a_run_holds: assert property (running && !selOvf
    && !(wr && hit(paddr, `CRF_OFS_CTRL)) |=> running) // see (R07)
    else $error("measurement ended without overflow");

  a_sw_stop: assert property (running && wr && hit(paddr, `CRF_OFS_CTRL)
    && !pwdata[`CRF_CTRL_RUN_BIT] |=> !running) // see (R07)
    else $error("clearing run bit did not stop");

  a_ovf_a_source: assert property (running && wrapA && ovfSel_q |-> selOvf)
    // see (R04)
    else $error("counter A overflow ignored");

  a_full_rate: assert property (running && !refSel_q |-> tickA) // see (R02)
    else $error("undivided clock missed a tick");

  a_b_counts_edge: assert property (running && oscSync && !oscPrev_q
    |=> cntB == $past(cntB) + 16'h0001) // see (R03)
    else $error("counter B missed an oscillator edge");

  a_high_write_b: assert property (ldB |=>
    cntB == {$past(pwdata[7:0]), $past(lowBuf_q)}) // see (R09)
    else $error("high byte write did not load counter B");

  a_low_write_b: assert property (wr && !running && hit(paddr,
    `CRF_OFS_B_LOW) |=> lowBuf_q == $past(pwdata[7:0]) && $stable(cntB))
    // see (R08)
    else $error("counter B low byte write misbehaved");

  a_high_read_a: assert property (rd && !running && hit(paddr,
    `CRF_OFS_A_HIGH) |=> lowBuf_q == $past(cntA[7:0])) // see (R10)
    else $error("counter A high read did not latch low byte");

  a_run_locks_read: assert property (running && rd && hit(paddr,
    `CRF_OFS_A_HIGH) |=> $stable(lowBuf_q)) // see (R12)
    else $error("high byte read while running latched");

  a_run_locks_bwr: assert property (running && wr && hit(paddr,
    `CRF_OFS_B_LOW) |=> $stable(lowBuf_q)) // see (R12)
    else $error("low byte write while running landed");

  a_flag_sticky: assert property (flag_q && !(wr && hit(paddr,
    `CRF_OFS_CLEAR) && pwdata[`CRF_FLAG_BIT]) |=> flag_q) // see (R05)
    else $error("done flag dropped without clear");

  a_select_route: assert property (1'b1 |=> switchCtrl.select[8] ==
    $past(chanHigh_q && !ioModeHigh)) // see (R13)
    else $error("channel eight routing wrong");

  a_pull_pair: assert property (1'b1 |=> switchCtrl.pullLow[1] ==
    $past(pull_q[0] && !(chanLow_q[1] && !ioModeLow[1]))) // see (R14)
    else $error("pair pull-low wrong on channel one");

  a_pull_ch8: assert property (1'b1 |=> switchCtrl.pullLow[8] ==
    $past(pull_q[`CRF_PAIR_CH8_BIT] && !(chanHigh_q && !ioModeHigh)))
    // see (R14)
    else $error("pull-low wrong on channel eight");

  a_sel_high_zero: assert property (setup && !pwrite && ioModeHigh
    && hit(paddr, `CRF_OFS_SEL_HIGH) |=> !prdata[0]) // see (R15)
    else $error("plain I/O channel eight select read nonzero");

  // Main scenarios worth seeing at least once
  c_ovf_a: cover property (running && ovfSel_q && selOvf);
  c_ovf_b: cover property (running && !ovfSel_q && selOvf);
  c_high_read: cover property (rd && !running && hit(paddr, `CRF_OFS_A_HIGH));
  c_irq: cover property ($rose(irq));
  c_sw_stop: cover property (running && wr && hit(paddr, `CRF_OFS_CTRL)
    && !pwdata[`CRF_CTRL_RUN_BIT]);
endmodule
`default_nettype wire

// [hdl/crf_params.svh]
// Register map, field positions, reset values and timing counts of the
// capacitance/resistance-to-frequency measurement block.
// Assumes byte addresses on an 8-bit APB address, one word per register.
`ifndef CRF_PARAMS_SVH
`define CRF_PARAMS_SVH
`define CRF_OFS_CTRL 8'h00
`define CRF_OFS_MODE 8'h04
`define CRF_OFS_A_LOW 8'h08
`define CRF_OFS_A_HIGH 8'h0c
`define CRF_OFS_B_LOW 8'h10
`define CRF_OFS_B_HIGH 8'h14
`define CRF_OFS_SEL_LOW 8'h18
`define CRF_OFS_SEL_HIGH 8'h1c
`define CRF_OFS_PULL 8'h20
`define CRF_OFS_STATUS 8'h24
`define CRF_OFS_CLEAR 8'h28
`define CRF_OFS_ENABLE 8'h2c
`define CRF_CTRL_RUN_BIT 4
`define CRF_CTRL_REFSEL_BIT 5
`define CRF_MODE_OVFSEL_BIT 1
`define CRF_FLAG_BIT 0
`define CRF_PAIR_CH8_BIT 4
`define CRF_BIT_RST 1'b0
`define CRF_BYTE_RST 8'h00
`define CRF_WORD_RST 32'h0000_0000
`define CRF_CNT_RST 16'h0000
`define CRF_PRE_RST 2'h0
`define CRF_PRE_LAST 2'h3
`endif

// [hdl/crf_pkg.sv]
// Types shared by the measurement block and its users.
// Assumes nothing beyond a SystemVerilog compiler.
package crf_pkg;
  typedef enum logic [1:0] {
    CRF_IDLE = 2'b01,
    CRF_RUN = 2'b10
  } crf_state_t;
  typedef struct packed {
    logic [8:0] select;
    logic [8:0] pullLow;
  } crf_switch_t;
endpackage

// [hdl/crf_sync.sv]
// Two-flip-flop synchroniser for one level from outside the clock domain.
// Assumes the input is a slow level compared with clk.
`timescale 1ns/1ps
`default_nettype none
module crf_sync (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic asyncIn,
  output logic syncOut
);
  logic meta_q;
  logic sync_q;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end else begin
      meta_q <= asyncIn;
      sync_q <= meta_q;
    end
  end

  assign syncOut = sync_q;
endmodule
`default_nettype wire

// [hdl/crf_counter.sv]
// Count-up counter with parallel load and a wrap indication.
// Assumes tick and load are single-cycle qualifiers on clk.
`timescale 1ns/1ps
`default_nettype none
`include "crf_params.svh"
module crf_counter #(
  parameter int WIDTH = 16
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic tick,
  input wire logic load,
  input wire logic [WIDTH-1:0] loadValue,
  output logic [WIDTH-1:0] count,
  output logic wrap
);
  logic [WIDTH-1:0] cnt_q;
  logic [WIDTH-1:0] cnt_d;

  always_comb begin
    cnt_d = cnt_q; // see (R18)
    if (load) begin
      cnt_d = loadValue;
    end else if (tick) begin
      cnt_d = cnt_q + 1'b1; // see (R01)
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign count = cnt_q;
  // Wrap from all ones to zero
  assign wrap = tick && (&cnt_q); // see (R18)
endmodule
`default_nettype wire

// [verif/crf_rc_osc.sv]
// Behavioural RC oscillator that feeds the converter's counter B input.
// Assumes a half period well above two system clocks.
`timescale 1ns/1ps
`default_nettype none
module crf_rc_osc #(
  parameter int HALF_NS = 20
) (
  input wire logic enable,
  output logic oscOut
);
  initial oscOut = 1'b0;
  // Free-running square wave while enabled, parked low otherwise
  always begin
    #(HALF_NS);
    oscOut = enable ? ~oscOut : 1'b0;
  end
endmodule
`default_nettype wire

// [verif/crf_freq_measure_tb.sv]
// Self-checking bench for the C/R to frequency measurement block.
// Assumes the block answers APB with pready and a behavioural RC oscillator.
`timescale 1ns/1ps
`default_nettype none
`include "crf_params.svh"
module crf_freq_measure_tb
  import crf_pkg::*;
  ;
  logic clk, reset_n, psel, penable, pwrite, pready, pslverr, irq;
  logic rcOscIn, oscOn, ioModeHigh, errFlag;
  logic [7:0] paddr, ioModeLow;
  logic [31:0] pwdata, prdata, rdVal, keepA;
  crf_switch_t switchCtrl;
  int n_errors, compares;

  always #2 clk = ~clk;

  crf_freq_measure crf_freq_measure_i (.clk(clk), .reset_n(reset_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rcOscIn(rcOscIn), .ioModeLow(ioModeLow), .ioModeHigh(ioModeHigh),
    .switchCtrl(switchCtrl), .irq(irq));
  crf_rc_osc crf_rc_osc_i (.enable(oscOn), .oscOut(rcOscIn));

  task automatic results;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One APB transfer; the request stands until pready is seen high, for at most 20 cycles
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rdVal = prdata;
    errFlag = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      n_errors++;
      $display("Error at %0t: no pready", $time);
      results();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rdVal, exp);
  endtask

  task automatic waitIrq(input int bound);
    int n;
    n = 0;
    while (irq !== 1'b1 && n < bound) begin
      @(posedge clk);
      n++;
    end
    if (irq !== 1'b1) begin
      n_errors++;
      $display("Error at %0t: no interrupt", $time);
      results();
    end
  endtask

  task automatic chkSwitch(input logic [8:0] sel, input logic [8:0] pull);
    @(posedge clk);
    #1;
    chk({23'h0, switchCtrl.select}, {23'h0, sel});
    chk({23'h0, switchCtrl.pullLow}, {23'h0, pull});
  endtask

  initial begin
    clk = 1'b0;
    reset_n = 1'b0;
    {psel, penable, pwrite, oscOn, ioModeHigh} = 5'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    ioModeLow = 8'h0f;
    n_errors = 0;
    compares = 0;
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    rd(`CRF_OFS_CTRL, 32'h0);
    rd(`CRF_OFS_STATUS, 32'h0);
    apb(1'b0, 8'h30, 32'h0);
    chk({31'h0, errFlag}, 32'h1);
    // Byte pair access through the shared low buffer
    wr(`CRF_OFS_A_LOW, 32'h34);
    wr(`CRF_OFS_A_HIGH, 32'h12);
    wr(`CRF_OFS_A_LOW, 32'h99);
    rd(`CRF_OFS_A_HIGH, 32'h12);
    rd(`CRF_OFS_A_LOW, 32'h34);
    // Counter A overflow with the divide-by-four reference
    wr(`CRF_OFS_ENABLE, 32'h1);
    wr(`CRF_OFS_MODE, 32'h2);
    wr(`CRF_OFS_A_LOW, 32'hf0);
    wr(`CRF_OFS_A_HIGH, 32'hff);
    wr(`CRF_OFS_CTRL, 32'h30);
    repeat (40) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    waitIrq(100);
    // Run bit cleared; the divide select stays as written
    rd(`CRF_OFS_CTRL, 32'h20);
    rd(`CRF_OFS_STATUS, 32'h1);
    rd(`CRF_OFS_A_HIGH, 32'h0);
    rd(`CRF_OFS_A_LOW, 32'h0);
    wr(`CRF_OFS_CLEAR, 32'h1);
    rd(`CRF_OFS_STATUS, 32'h0);
    // Undivided reference finishes within 16 ticks plus latency
    wr(`CRF_OFS_A_LOW, 32'hf0);
    wr(`CRF_OFS_A_HIGH, 32'hff);
    wr(`CRF_OFS_CTRL, 32'h10);
    waitIrq(24);
    wr(`CRF_OFS_ENABLE, 32'h0);
    #1;
    chk({31'h0, irq}, 32'h0);
    rd(`CRF_OFS_STATUS, 32'h1);
    wr(`CRF_OFS_CLEAR, 32'h1);
    rd(`CRF_OFS_STATUS, 32'h0);
    wr(`CRF_OFS_ENABLE, 32'h1);
    // Counter B overflow, counter A access locked while running
    wr(`CRF_OFS_MODE, 32'h0);
    wr(`CRF_OFS_A_LOW, 32'h0);
    wr(`CRF_OFS_A_HIGH, 32'h0);
    wr(`CRF_OFS_B_LOW, 32'hfd);
    wr(`CRF_OFS_B_HIGH, 32'hff);
    oscOn <= 1'b1;
    wr(`CRF_OFS_CTRL, 32'h10);
    wr(`CRF_OFS_A_LOW, 32'h55);
    wr(`CRF_OFS_A_HIGH, 32'h55);
    rd(`CRF_OFS_A_HIGH, 32'h0);
    waitIrq(200);
    rd(`CRF_OFS_B_HIGH, 32'h0);
    rd(`CRF_OFS_B_LOW, 32'h0);
    rd(`CRF_OFS_A_HIGH, 32'h0);
    apb(1'b0, `CRF_OFS_A_LOW, 32'h0);
    keepA = rdVal;
    chk({31'h0, keepA != 32'h0}, 32'h1);
    repeat (20) @(posedge clk);
    rd(`CRF_OFS_A_HIGH, 32'h0);
    rd(`CRF_OFS_A_LOW, keepA);
    oscOn <= 1'b0;
    // Channel routing; channels 0 to 3 are plain I/O
    wr(`CRF_OFS_SEL_LOW, 32'h1f);
    rd(`CRF_OFS_SEL_LOW, 32'h10);
    wr(`CRF_OFS_PULL, 32'h1c);
    chkSwitch(9'h010, 9'h1e0);
    wr(`CRF_OFS_SEL_HIGH, 32'h1);
    rd(`CRF_OFS_SEL_HIGH, 32'h1);
    chkSwitch(9'h110, 9'h0e0);
    ioModeHigh <= 1'b1;
    rd(`CRF_OFS_SEL_HIGH, 32'h0);
    // Channel 8 now plain I/O, so its pull-low bit is cleared
    wr(`CRF_OFS_PULL, 32'h0c);
    chkSwitch(9'h010, 9'h0e0);
    results();
  end
endmodule
`default_nettype wire
